// ### rtl/asr_receiver.sv
// Asynchronous serial receiver with AXI4-Lite register access
//
// Operation
// - A character starts only on a falling edge of the idle line.
// - Half a bit later the start bit is rechecked and must be low.
// - A high start centre abandons the character silently and resumes hunting.
// - Each later bit centre is one bit apart; data bits are decided by majority vote.
// - Stop bit sampled one bit after data; low gives a framing error.
// - After the stop sample the character enters the FIFO, setting pending.
// - Reading the data port returns the oldest entry and removes it.
// - Pending is high while enabled and the FIFO is not empty; read-only.
// - Interrupt needs pending, receive, peripheral and global enables all set.
// - Each entry keeps its framing error; flag shows the oldest entry.
// - Reading a character exposes the next entry's framing error.
// - Port enable low resets the block; receive enable low keeps framing flag.
// - Framing errors raise no interrupt and do not stop reception.
// - FIFO holds two; a third complete character sets overrun.
// - Overrun blocks new characters until receive or port enable clears.
// - Nine-bit mode shifts nine bits; oldest ninth bit readable as status.
// - Address detection, in nine-bit mode only, keeps only characters with the ninth bit set.
// - Line sampled on a sixteen-times tick; shifter moves once per bit.
// - Reception runs only with receive and port enabled and clocked mode clear.
//
// Decided for this implementation: the AXI4-Lite register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module asr_receiver (
	input wire logic CLK,
	input wire logic RSTN,
	input wire logic BAUD_TICK16,
	input wire logic RX_LINE_PIN,
	output logic RX_IRQ,
	input wire logic [3:0] AWADDR,
	input wire logic AWVALID,
	output logic AWREADY,
	input wire logic [31:0] WDATA,
	input wire logic [3:0] WSTRB,
	input wire logic WVALID,
	output logic WREADY,
	output logic [1:0] BRESP,
	output logic BVALID,
	input wire logic BREADY,
	input wire logic [3:0] ARADDR,
	input wire logic ARVALID,
	output logic ARREADY,
	output logic [31:0] RDATA,
	output logic [1:0] RRESP,
	output logic RVALID,
	input wire logic RREADY
);
	asr_pkg::asr_state_t q, d;

	// Decoded control bits of the current state
	logic port_enable, continuous_rx_enable, nine_bit_rx_select, addr_detect_enable;
	logic rx_active, tick, sample_pt, vote, empty;
	logic [3:0] last_bit;
	asr_pkg::asr_entry_t head;
	assign port_enable = q.ctrl[asr_pkg::CTRL_PORT_EN];
	assign continuous_rx_enable = q.ctrl[asr_pkg::CTRL_CONT_RX];
	assign nine_bit_rx_select = q.ctrl[asr_pkg::CTRL_NINE_BIT];
	assign addr_detect_enable = q.ctrl[asr_pkg::CTRL_ADDR_DET];
	assign rx_active = continuous_rx_enable && port_enable &&
		!q.ctrl[asr_pkg::CTRL_CLOCKED];
	assign tick = BAUD_TICK16;
	assign sample_pt = tick && (q.ovs == asr_pkg::OVS_LAST);
	// Three votes around mid-bit; the last arrives with this sample
	assign vote = (q.votes[0] & q.votes[1]) | (q.votes[0] & q.rx_s) |
		(q.votes[1] & q.rx_s);
	assign last_bit = nine_bit_rx_select ? 4'h8 : 4'h7;
	assign empty = (q.count == 2'h0);
	assign head = q.fifo[q.rd_ptr];

	// Read of the data port pops the FIFO
	logic rd_take, rd_data;
	assign rd_take = ARVALID && !q.axo.rvalid;
	assign rd_data = rd_take && (ARADDR == asr_pkg::OFF_DATA) && !empty;

	// Next state
	always_comb begin
		logic [31:0] rword;
		logic wr_ok;
		logic pushed;
		asr_pkg::asr_entry_t ent;
		rword = 32'h0;
		wr_ok = 1'b0;
		pushed = 1'b0;
		ent = '0;
		d = q;
		// Line synchroniser; only the second stage and its delayed copy rx_prev are looked at
		d.rx_m = RX_LINE_PIN;
		d.rx_s = q.rx_m;
		d.rx_prev = q.rx_s;

		// Bit recovery on the oversampling tick
		if (!rx_active) begin
			d.st = asr_pkg::RX_HUNT;
		end else begin
			case (q.st)
				asr_pkg::RX_HUNT: begin
					if (q.rx_prev && !q.rx_s) begin
						d.st = asr_pkg::RX_START;
						d.ovs = 4'h0;
					end
				end
				asr_pkg::RX_START: begin
					if (tick) begin
						d.ovs = q.ovs + 4'h1;
						if (q.ovs == asr_pkg::OVS_HALF) begin
							d.ovs = 4'h0;
							d.bitn = 4'h0;
							if (q.rx_s) begin
								d.st = asr_pkg::RX_HUNT;
							end else begin
								d.st = asr_pkg::RX_DATA;
							end
						end
					end
				end
				asr_pkg::RX_DATA: begin
					if (tick) begin
						d.ovs = q.ovs + 4'h1;
						if (q.ovs == asr_pkg::VOTE_A) begin
							d.votes[0] = q.rx_s;
						end
						if (q.ovs == asr_pkg::VOTE_B) begin
							d.votes[1] = q.rx_s;
						end
					end
					// Votes on the two ticks before the centre; shift once per bit
					if (sample_pt) begin
						d.rx_shift_reg = {vote, q.rx_shift_reg[8:1]};
						d.bitn = q.bitn + 4'h1;
						if (q.bitn == last_bit) begin
							d.st = asr_pkg::RX_STOP;
						end
					end
				end
				asr_pkg::RX_STOP: begin
					if (tick) begin
						d.ovs = q.ovs + 4'h1;
					end
					if (sample_pt) begin
						d.st = asr_pkg::RX_HUNT;
						pushed = 1'b1;
					end
				end
				default: d.st = asr_pkg::RX_HUNT;
			endcase
		end
		// Vote sample C is the stop-bit / centre level itself
		ent.frame_err_flag = !q.rx_s;
		ent.data = nine_bit_rx_select ? q.rx_shift_reg : {1'b0, q.rx_shift_reg[8:1]};
		if (addr_detect_enable && nine_bit_rx_select && !ent.data[8]) begin
			pushed = 1'b0;
		end

		// FIFO pop by a data-port read
		if (rd_data) begin
			d.rd_ptr = !q.rd_ptr;
			d.count = q.count - 2'h1;
		end
		// Push after the stop sample; full means overrun
		if (pushed && !q.overrun_flag) begin
			if (q.count == 2'(asr_pkg::FIFO_DEPTH) && !rd_data) begin
				d.overrun_flag = 1'b1;
			end else begin
				d.fifo[q.rd_ptr + 1'(q.count)] = ent;
				d.count = d.count + 2'h1;
			end
		end
		// Overrun cleared only by dropping the enables
		if (!continuous_rx_enable || !port_enable) begin
			d.overrun_flag = 1'b0;
		end

		// Write channel: address and data in either order
		if (AWVALID && !q.aw_got) begin
			d.aw_got = 1'b1;
			d.aw_addr = AWADDR;
		end
		if (WVALID && !q.w_got) begin
			d.w_got = 1'b1;
			d.w_data = WDATA;
			d.w_strb = WSTRB;
		end
		d.axo.awready = !d.aw_got && !q.axo.bvalid;
		d.axo.wready = !d.w_got && !q.axo.bvalid;
		if (q.aw_got && q.w_got && !q.axo.bvalid) begin
			wr_ok = (q.aw_addr == asr_pkg::OFF_CTRL);
			if (wr_ok && q.w_strb[0]) begin
				d.ctrl = q.w_data[7:0];
			end
			// Status and data are read-only; writes there are refused
			d.axo.bresp = wr_ok ? asr_pkg::RESP_OKAY : asr_pkg::RESP_SLVERR;
			d.axo.bvalid = 1'b1;
			d.aw_got = 1'b0;
			d.w_got = 1'b0;
			d.axo.awready = 1'b0;
			d.axo.wready = 1'b0;
		end
		if (q.axo.bvalid && BREADY) begin
			d.axo.bvalid = 1'b0;
			d.axo.awready = 1'b1;
			d.axo.wready = 1'b1;
		end

		// Read channel: one-cycle answer
		if (rd_take) begin
			d.axo.rvalid = 1'b1;
			d.axo.rresp = asr_pkg::RESP_OKAY;
			case (ARADDR)
				asr_pkg::OFF_CTRL: rword[7:0] = q.ctrl;
				asr_pkg::OFF_STATUS: begin
					rword[asr_pkg::STAT_NINTH] = !empty && head.data[8];
					rword[asr_pkg::STAT_OVERRUN] = q.overrun_flag;
					rword[asr_pkg::STAT_FRAME_ERR] = !empty && head.frame_err_flag;
					rword[asr_pkg::STAT_PENDING] = port_enable && !empty;
					rword[asr_pkg::STAT_IDLE] = (q.st == asr_pkg::RX_HUNT);
				end
				asr_pkg::OFF_DATA: rword[7:0] = empty ? 8'h00 : head.data[7:0];
				default: d.axo.rresp = asr_pkg::RESP_SLVERR;
			endcase
			d.axo.rdata = rword;
		end
		if (q.axo.rvalid && RREADY) begin
			d.axo.rvalid = 1'b0;
		end
		d.axo.arready = !d.axo.rvalid;

		// Interrupt request from pending and all three enables
		d.irq = port_enable && (d.count != 2'h0) && d.ctrl[asr_pkg::CTRL_RX_IE] &&
			d.ctrl[asr_pkg::CTRL_PERIPH_IE] && d.ctrl[asr_pkg::CTRL_GLOBAL_IE];

		// Port disable resets the receiver path and FIFO, keeping control
		if (!port_enable) begin
			d.st = asr_pkg::RX_HUNT;
			d.count = 2'h0;
			d.rd_ptr = 1'b0;
			d.fifo = '0;
		end
	end

	// State register, synchronous active-low reset
	always_ff @(posedge CLK) begin
		if (!RSTN) begin
			q <= '0;
			q.ctrl <= asr_pkg::CTRL_RESET;
			q.rx_m <= 1'b1;
			q.rx_s <= 1'b1;
			q.rx_prev <= 1'b1;
			q.axo.awready <= 1'b1;
			q.axo.wready <= 1'b1;
			q.axo.arready <= 1'b1;
		end else begin
			q <= d;
		end
	end

	// Outputs straight from the state register
	assign RX_IRQ = q.irq;
	assign AWREADY = q.axo.awready;
	assign WREADY = q.axo.wready;
	assign BRESP = q.axo.bresp;
	assign BVALID = q.axo.bvalid;
	assign ARREADY = q.axo.arready;
	assign RDATA = q.axo.rdata;
	assign RRESP = q.axo.rresp;
	assign RVALID = q.axo.rvalid;

	// Checks
	sequence s_fall;
		q.st == asr_pkg::RX_HUNT && q.rx_prev && !q.rx_s && rx_active;
	endsequence
	// Stop sample landing in an empty FIFO; a same-cycle read moves the count itself
	sequence s_push_empty;
		rx_active && q.st == asr_pkg::RX_STOP && sample_pt && q.count == 2'h0 &&
		!q.overrun_flag && !addr_detect_enable && !rd_data;
	endsequence
	// Stop sample of a plain character while address detection filters
	sequence s_addr_miss;
		rx_active && q.st == asr_pkg::RX_STOP && sample_pt && addr_detect_enable &&
		nine_bit_rx_select && !q.rx_shift_reg[8] && !rd_data;
	endsequence

	// Start-bit detection and validation
	a_start_edge: assert property (@(posedge CLK) disable iff (!RSTN)
		s_fall |=> q.st == asr_pkg::RX_START)
		else $error("falling edge did not start");
	a_start_abort: assert property (@(posedge CLK) disable iff (!RSTN)
		(rx_active && q.st == asr_pkg::RX_START && tick && q.ovs == asr_pkg::OVS_HALF
		&& q.rx_s) |=> q.st == asr_pkg::RX_HUNT && ($stable(q.count) || $past(rd_data))
		&& (!q.overrun_flag || $past(q.overrun_flag)))
		else $error("start abort wrong");
	a_start_ok: assert property (@(posedge CLK) disable iff (!RSTN)
		(rx_active && q.st == asr_pkg::RX_START && tick && q.ovs == asr_pkg::OVS_HALF
		&& !q.rx_s) |=> q.st == asr_pkg::RX_DATA && q.bitn == 4'h0)
		else $error("valid start not taken");

	// Bit recovery: one shift per bit centre, exact bit count
	a_shift_hold: assert property (@(posedge CLK) disable iff (!RSTN)
		!(rx_active && q.st == asr_pkg::RX_DATA && sample_pt) |=> $stable(q.rx_shift_reg))
		else $error("shift register moved between bits");
	a_mid_bit: assert property (@(posedge CLK) disable iff (!RSTN)
		(rx_active && q.st == asr_pkg::RX_DATA && sample_pt && q.bitn != last_bit)
		|=> q.st == asr_pkg::RX_DATA && q.bitn == $past(q.bitn) + 4'h1)
		else $error("data bit not counted");
	a_last_bit: assert property (@(posedge CLK) disable iff (!RSTN)
		(rx_active && q.st == asr_pkg::RX_DATA && sample_pt && q.bitn == last_bit)
		|=> q.st == asr_pkg::RX_STOP)
		else $error("last data bit missed");

	// FIFO, framing status and overrun
	a_push_one: assert property (@(posedge CLK) disable iff (!RSTN)
		s_push_empty |=> q.count == 2'h1)
		else $error("character not pushed");
	a_frame_flag: assert property (@(posedge CLK) disable iff (!RSTN)
		s_push_empty |=> q.fifo[q.rd_ptr].frame_err_flag == !$past(q.rx_s))
		else $error("framing status not stored");
	a_ninth_store: assert property (@(posedge CLK) disable iff (!RSTN)
		s_push_empty ##0 nine_bit_rx_select
		|=> q.fifo[q.rd_ptr].data == $past(q.rx_shift_reg))
		else $error("nine-bit character not stored");
	a_addr_drop: assert property (@(posedge CLK) disable iff (!RSTN)
		s_addr_miss |=> $stable(q.count))
		else $error("filtered character stored");
	a_overrun_set: assert property (@(posedge CLK) disable iff (!RSTN)
		(rx_active && q.st == asr_pkg::RX_STOP && sample_pt && q.count == 2'h2 &&
		!addr_detect_enable && !rd_data) |=> q.overrun_flag)
		else $error("overrun not set");
	a_overrun_block: assert property (@(posedge CLK) disable iff (!RSTN)
		q.overrun_flag && port_enable && !rd_data |=> q.count == $past(q.count))
		else $error("char accepted in overrun");
	a_pop_read: assert property (@(posedge CLK) disable iff (!RSTN)
		rd_data && !(q.st == asr_pkg::RX_STOP && sample_pt) && port_enable
		|=> q.count == $past(q.count) - 2'h1 && q.rd_ptr != $past(q.rd_ptr))
		else $error("read did not pop");

	// Enables and interrupt
	a_rx_off_keep: assert property (@(posedge CLK) disable iff (!RSTN)
		port_enable && !continuous_rx_enable && !rd_data
		|=> $stable(q.fifo) && $stable(q.count))
		else $error("receive disable touched the FIFO");
	a_irq_gate: assert property (@(posedge CLK) disable iff (!RSTN)
		RX_IRQ |-> port_enable && q.count != 2'h0 && q.ctrl[asr_pkg::CTRL_GLOBAL_IE] &&
		q.ctrl[asr_pkg::CTRL_RX_IE] && q.ctrl[asr_pkg::CTRL_PERIPH_IE])
		else $error("irq without cause");
	a_port_reset: assert property (@(posedge CLK) disable iff (!RSTN)
		!port_enable |=> q.count == 2'h0 && !q.overrun_flag)
		else $error("port disable did not reset");
endmodule
`default_nettype wire

// ### rtl/asr_pkg.sv
// Shared constants and types for the asynchronous serial receiver
package asr_pkg;
	// Register byte offsets on the AXI4-Lite bus
	localparam logic [3:0] OFF_CTRL = 4'h0;
	localparam logic [3:0] OFF_STATUS = 4'h4;
	localparam logic [3:0] OFF_DATA = 4'h8;
	// Control register field positions
	localparam int CTRL_PORT_EN = 0;
	localparam int CTRL_CONT_RX = 1;
	localparam int CTRL_NINE_BIT = 2;
	localparam int CTRL_ADDR_DET = 3;
	localparam int CTRL_CLOCKED = 4;
	localparam int CTRL_RX_IE = 5;
	localparam int CTRL_PERIPH_IE = 6;
	localparam int CTRL_GLOBAL_IE = 7;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	// Status register field positions
	localparam int STAT_NINTH = 0;
	localparam int STAT_OVERRUN = 1;
	localparam int STAT_FRAME_ERR = 2;
	localparam int STAT_PENDING = 3;
	localparam int STAT_IDLE = 4;
	// Oversampling figures
	localparam logic [3:0] OVS_LAST = 4'hf;
	localparam logic [3:0] OVS_HALF = 4'h7;
	// Votes on the two ticks before the centre and on the centre itself, counted from the last centre
	localparam logic [3:0] VOTE_A = 4'hd;
	localparam logic [3:0] VOTE_B = 4'he;
	localparam logic [3:0] VOTE_C = 4'hf;
	localparam int FIFO_DEPTH = 2;
	// AXI responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		RX_HUNT = 2'b00,
		RX_START = 2'b01,
		RX_DATA = 2'b10,
		RX_STOP = 2'b11
	} asr_rx_state_t;

	// One FIFO entry: framing error, ninth bit, low eight bits
	typedef struct packed {
		logic frame_err_flag;
		logic [8:0] data;
	} asr_entry_t;

	// AXI4-Lite slave outputs grouped
	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} asr_axi_out_t;

	// Whole state of the receiver
	typedef struct packed {
		logic [7:0] ctrl;
		logic rx_m;
		logic rx_s;
		logic rx_prev;
		asr_rx_state_t st;
		logic [3:0] ovs;
		logic [3:0] bitn;
		logic [2:0] votes;
		logic [8:0] rx_shift_reg;
		asr_entry_t [1:0] fifo;
		logic rd_ptr;
		logic [1:0] count;
		logic overrun_flag;
		logic irq;
		logic aw_got;
		logic w_got;
		logic [3:0] aw_addr;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		asr_axi_out_t axo;
	} asr_state_t;
endpackage

// ### verif/asr_line_tx.sv
// Remote line driver sending one framed character
`timescale 1ns/10ps
`default_nettype none
module asr_line_tx (
	input wire logic clk,
	input wire logic tick,
	input wire logic go,
	input wire logic [11:0] frame,
	input wire logic [3:0] len,
	input wire logic [4:0] tpb,
	output logic line,
	output logic busy
);
	logic [11:0] sh_q;
	logic [3:0] n_q;
	logic [4:0] t_q;
	initial begin
		line = 1'b1;
		busy = 1'b0;
	end
	// Bits leave LSB first, tpb ticks each; line rests high after the last
	always @(posedge clk) begin
		if (go && !busy) begin
			busy <= 1'b1;
			sh_q <= frame;
			n_q <= len;
			t_q <= 5'h00;
			line <= frame[0];
		end else if (busy && tick) begin
			t_q <= t_q + 5'h01;
			if (t_q == tpb - 5'h01) begin
				t_q <= 5'h00;
				sh_q <= sh_q >> 1;
				n_q <= n_q - 4'h1;
				line <= (n_q == 4'h1) ? 1'b1 : sh_q[1];
				busy <= (n_q != 4'h1);
			end
		end
	end
endmodule
`default_nettype wire

// ### verif/asr_receiver_test.sv
// Self-checking bench for the asynchronous serial receiver
`timescale 1ns/10ps
`default_nettype none
module asr_receiver_test;
	logic CLK = 1'b0, RSTN = 1'b0, BAUD_TICK16 = 1'b0, go = 1'b0;
	logic AWVALID = 1'b0, WVALID = 1'b0, ARVALID = 1'b0, BREADY = 1'b1, RREADY = 1'b1;
	logic RX_IRQ, AWREADY, WREADY, BVALID, ARREADY, RVALID, line_w, busy_w;
	logic [3:0] AWADDR = 4'h0, ARADDR = 4'h0, WSTRB = 4'hf, len = 4'h0;
	logic [31:0] WDATA = 32'h0, RDATA, v, rs = 32'h00015990;
	logic [1:0] BRESP, RRESP, r, tdiv = 2'h0;
	logic [11:0] frame = 12'hfff;
	logic [4:0] tpb = 5'h10;
	logic [7:0] mctrl = 8'h00;
	logic [7:0] seq [4] = '{8'h01, 8'h05, 8'h0d, 8'h0f};
	logic movr = 1'b0;
	logic [9:0] mq[$];
	int fail_count = 0, checked = 0;
	always #4 CLK = ~CLK;
	// Tick every fourth clock, so a bit lasts 64 clocks
	always @(posedge CLK) begin
		tdiv <= tdiv + 2'h1;
		BAUD_TICK16 <= (tdiv == 2'h3);
	end
	asr_receiver dut_u (.CLK(CLK), .RSTN(RSTN), .BAUD_TICK16(BAUD_TICK16),
		.RX_LINE_PIN(line_w), .RX_IRQ(RX_IRQ), .AWADDR(AWADDR), .AWVALID(AWVALID),
		.AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY),
		.BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
		.ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY));
	asr_line_tx tx_u (.clk(CLK), .tick(BAUD_TICK16), .go(go), .frame(frame), .len(len),
		.tpb(tpb), .line(line_w), .busy(busy_w));
	function automatic logic [31:0] rnd();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs;
	endfunction
	// Expected status nibble: pending, framing error, overrun, ninth bit
	function automatic logic [3:0] est();
		logic [9:0] h;
		h = (mq.size() > 0) ? mq[0] : 10'h000;
		return {mctrl[0] && mctrl[1] && mq.size() > 0, h[9], movr, h[8]};
	endfunction
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		checked++;
		if (e !== s) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// Bus write: address and data offered together, each dropped when taken
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		logic aw, w;
		aw = 1'b1;
		w = 1'b1;
		AWADDR <= a;
		WDATA <= d;
		AWVALID <= 1'b1;
		WVALID <= 1'b1;
		while (aw || w) begin
			@(posedge CLK);
			if (aw && AWREADY === 1'b1) begin
				aw = 1'b0;
				AWVALID <= 1'b0;
			end
			if (w && WREADY === 1'b1) begin
				w = 1'b0;
				WVALID <= 1'b0;
			end
		end
		while (BVALID !== 1'b1) @(posedge CLK);
		chk("bresp", a == asr_pkg::OFF_CTRL ? asr_pkg::RESP_OKAY : asr_pkg::RESP_SLVERR, BRESP);
		if (a == asr_pkg::OFF_CTRL) mctrl = d[7:0];
	endtask
	task automatic rd(input logic [3:0] a);
		ARADDR <= a;
		ARVALID <= 1'b1;
		do @(posedge CLK); while (ARREADY !== 1'b1);
		ARVALID <= 1'b0;
		while (RVALID !== 1'b1) @(posedge CLK);
		v = RDATA;
		r = RRESP;
	endtask
	task automatic ctl(input logic [7:0] d);
		wr(asr_pkg::OFF_CTRL, {24'h0, d});
	endtask
	task automatic stat(input string nm);
		rd(asr_pkg::OFF_STATUS);
		chk(nm, est(), v[3:0]);
	endtask
	// Status first, then the data read that advances the queue
	task automatic pop();
		stat("status before pop");
		rd(asr_pkg::OFF_DATA);
		chk("data", mq[0][7:0], v[7:0]);
		void'(mq.pop_front());
	endtask
	task automatic drive(input logic [11:0] f, input logic [3:0] n, input logic [4:0] t);
		frame <= f;
		len <= n;
		tpb <= t;
		go <= 1'b1;
		@(posedge CLK);
		go <= 1'b0;
		do @(posedge CLK); while (busy_w);
		repeat (8) @(posedge CLK);
	endtask
	// One character; the model drops it when filtered or overrun
	task automatic send(input logic [8:0] d, input logic stp);
		if (mctrl[2]) drive({1'b1, stp, d, 1'b0}, 4'hb, 5'h10);
		else drive({2'b11, stp, d[7:0], 1'b0}, 4'ha, 5'h10);
		if (mctrl[0] && mctrl[1] && !mctrl[4] && !movr && !(mctrl[3] && !d[8])) begin
			if (mq.size() == 2) movr = 1'b1;
			else mq.push_back({!stp, mctrl[2] & d[8], d[7:0]});
		end
	endtask
	initial begin
		repeat (40000) @(posedge CLK);
		fail_count++;
		report_and_stop();
	end
	initial begin
		repeat (8) @(posedge CLK);
		RSTN <= 1'b1;
		@(posedge CLK);
		rd(asr_pkg::OFF_CTRL);
		chk("ctrl reset", {24'h0, asr_pkg::CTRL_RESET}, v);
		ctl(8'h03);
		wr(asr_pkg::OFF_STATUS, 32'h0000001f);
		stat("status after write");
		rd(4'hc);
		chk("unmapped resp", asr_pkg::RESP_SLVERR, r);
		$display("test registers ended");
		for (int i = 0; i < 2; i++) begin
			v = rnd();
			send({1'b0, v[7:0]}, i == 0);
		end
		stat("two stored");
		chk("irq disabled", 1'b0, RX_IRQ);
		pop();
		pop();
		stat("drained");
		for (int i = 0; i < 4; i++) begin
			v = rnd();
			send({1'b0, v[7:0]}, 1'b1);
		end
		stat("overrun");
		pop();
		pop();
		ctl(8'h01);
		movr = 1'b0;
		ctl(8'h03);
		stat("overrun cleared");
		$display("test stream and overrun ended");
		foreach (seq[i]) ctl(seq[i]);
		send(9'h055, 1'b1);
		send(9'h1a5, 1'b1);
		stat("address kept");
		pop();
		ctl(8'h07);
		send(9'h033, 1'b1);
		pop();
		$display("test addressing ended");
		ctl(8'h13);
		send(9'h05a, 1'b1);
		stat("clocked mode ignored");
		ctl(8'he3);
		drive(12'hffe, 4'h1, 5'h04);
		repeat (64) @(posedge CLK);
		stat("glitch dropped");
		send(9'h0c3, 1'b1);
		repeat (2) @(posedge CLK);
		chk("irq set", 1'b1, RX_IRQ);
		ctl(8'h63);
		repeat (2) @(posedge CLK);
		chk("irq masked", 1'b0, RX_IRQ);
		pop();
		send(9'h0aa, 1'b0);
		ctl(8'h00);
		mq.delete();
		stat("port off");
		$display("test glitch, interrupt and disable ended");
		report_and_stop();
	end
endmodule
`default_nettype wire
